// ---- kbc_host_port_and_serial_link.sv ----
/*
  Keyboard controller core: host read/write port, keyboard and mouse serial
  links, open-drain port bits and output port with delayed reset bit.
  Assumes one 10 MHz clock; every pin input is asynchronous and is
  synchronised here; three-state wires are resolved outside.
*/
`timescale 1ns/1ps
`include "kbc_cfg.svh"

// Contract
// - Strobes, select and chip select must stay active one clock to count.
// - Read data driven while read and chip select low, plus one clock after.
// - First test input is the keyboard clock in both modes.
// - Second test input is keyboard data, or mouse clock in second mode.
// - Writing one to a port bit drives high one 8 MHz cycle, then floats.
// - Lock behaviour enabled when strap low, disabled when high.
// - On transmit device clocks; controller pulls clock low 250 us then 60 us.
// - On transmit controller drives data incl. stop; device drives ack only.
// - Transmit aborts with timeout when any of three intervals overruns.
// - On receive device clocks; controller holds clock low 60 us after.
// - Receive aborts with timeout when frame overruns its maximum.
// - Output port command shows on pins within six clocks.
// - System-reset bit change is delayed by four to eight microseconds.
// - Debug output shows internal state; nothing depends on it.
// - Writing zero drives the port bit low; one releases it.
module kbc_host_port_and_serial_link #(
  parameter int unsigned TMO_TX_FIRST = `KBC_US_TO_CYC(`KBC_TX_FIRST_CLK_MAX_US),
  parameter int unsigned TMO_TX_FRAME = `KBC_US_TO_CYC(`KBC_TX_FRAME_MAX_US),
  parameter int unsigned TMO_TX_ACK   = `KBC_US_TO_CYC(`KBC_TX_ACK_MAX_US),
  parameter int unsigned TMO_RX_FRAME = `KBC_US_TO_CYC(`KBC_RX_FRAME_MAX_US),
  parameter int unsigned BIDIR_BITS   = 6
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  // Host port
  input  wire kbc_pkg::host_ctl_s    host_ctl,
  input  wire logic [7:0]            host_data_in,
  output logic [7:0]                 host_data_out,
  output logic                       host_data_oe,
  // Mode and strap
  input  wire logic                  ps2_mode,
  input  wire logic                  lock_enable_strap_n,
  // Test inputs
  input  wire logic                  kb_clock_in,
  input  wire logic                  kb_data_or_mouse_clock_in,
  // Keyboard lines
  output logic                       keyboard_clock_line_out,
  output logic                       keyboard_clock_line_oe,
  input  wire logic                  keyboard_data_line_in,
  output logic                       keyboard_data_line_out,
  output logic                       keyboard_data_line_oe,
  // Mouse lines
  output logic                       mouse_clock_line_out,
  output logic                       mouse_clock_line_oe,
  input  wire logic                  mouse_data_line_in,
  output logic                       mouse_data_line_out,
  output logic                       mouse_data_line_oe,
  // Port bits
  input  wire logic [BIDIR_BITS-1:0] bidir_port_bits_in,
  output logic [BIDIR_BITS-1:0]      bidir_port_bits_out,
  output logic [BIDIR_BITS-1:0]      bidir_port_bits_oe,
  input  wire logic [1:0]            input_only_bits,
  output logic [7:0]                 output_port_bits,
  // Debug
  output logic                       debug_sync
);
  import kbc_pkg::*;

  localparam int unsigned SYNC_W   = 4 + 8 + 4 + 2 + 2 + BIDIR_BITS;
  localparam int unsigned SYSRST_W = 8;
  localparam logic [SYSRST_W-1:0] SYSRST_CYC =
    SYSRST_W'(`KBC_US_TO_CYC(`KBC_SYSRST_DELAY_MIN_US));
  localparam logic [1:0] DRIVE_CYC = 2'(`KBC_PULLUP_DRIVE_CYC);

  // Two-stage synchroniser for every pin input
  logic [SYNC_W-1:0] sync1_q, sync2_q;
  wire  [SYNC_W-1:0] pins_raw = {host_ctl, host_data_in, kb_clock_in,
                                 kb_data_or_mouse_clock_in, keyboard_data_line_in,
                                 mouse_data_line_in, ps2_mode, lock_enable_strap_n,
                                 input_only_bits, bidir_port_bits_in};

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_q <= '1;
      sync2_q <= '1;
    end
    else
    begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  // Named views of the synchronised pins
  host_ctl_s              ctl_s;
  logic [7:0]             hdata_s;
  logic                   kb_clock_in_s, kb_data_or_mouse_clock_in_s, kdat_s, mdat_s, mode_s, strap_n_s;
  logic [1:0]             inonly_s;
  logic [BIDIR_BITS-1:0]  bidir_in_s;
  assign {ctl_s, hdata_s, kb_clock_in_s, kb_data_or_mouse_clock_in_s, kdat_s, mdat_s, mode_s, strap_n_s,
          inonly_s, bidir_in_s} = sync2_q;

  // Host strobe decode
  wire wr_act = ~ctl_s.wr_n & ~ctl_s.cs_n;
  wire rd_act = ~ctl_s.rd_n & ~ctl_s.cs_n;
  logic       wr_act_q, rd_act_q, wr_a0_q, rd_a0_q;
  logic [7:0] wr_data_q;
  wire wr_commit = wr_act_q & ~wr_act;
  wire rd_end    = rd_act_q & ~rd_act;

  // Write data taken while the strobe stands, committed at its release
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_act_q  <= 1'b0;
      rd_act_q  <= 1'b0;
      wr_a0_q   <= 1'b0;
      rd_a0_q   <= 1'b0;
      wr_data_q <= '0;
    end
    else
    begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act)
      begin
        wr_data_q <= hdata_s;
        wr_a0_q   <= ctl_s.cmd_data_select;
      end
      if (rd_act)
        rd_a0_q <= ctl_s.cmd_data_select;
    end
  end

  // Command decode and write routing
  data_dest_e dest_q;
  logic       last_cmd_q;
  wire data_wr    = wr_commit & ~wr_a0_q;
  wire kb_tx_req  = data_wr & (dest_q == DST_KEYBOARD);
  wire ms_tx_req  = data_wr & (dest_q == DST_MOUSE);
  wire outport_wr = data_wr & (dest_q == DST_OUTPORT);
  wire bidir_wr   = data_wr & (dest_q == DST_BIDIR);
  wire data_dest_e cmd_dest =
    (wr_data_q == `KBC_CMD_WR_OUTPORT) ? DST_OUTPORT :
    (wr_data_q == `KBC_CMD_WR_BIDIR)   ? DST_BIDIR   :
    (wr_data_q == `KBC_CMD_WR_MOUSE)   ? DST_MOUSE   : DST_KEYBOARD;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dest_q     <= DST_KEYBOARD;
      last_cmd_q <= 1'b0;
    end
    else if (wr_commit)
    begin
      dest_q     <= wr_a0_q ? cmd_dest : DST_KEYBOARD;
      last_cmd_q <= wr_a0_q;
    end
  end

  // Link engines; second test input is shared by mode
  wire kb_data_s = mode_s ? kdat_s : kb_data_or_mouse_clock_in_s;
  wire lock_on   = ~strap_n_s & ~inonly_s[`KBC_KEYLOCK_BIT];
  logic      rx_full_q, rx_mouse_q, tmo_q, par_q;
  logic      kb_rdy, kb_rxv, kb_tmo, kb_busy, ms_rdy, ms_rxv, ms_tmo, ms_busy;
  rx_frame_s kb_frm, ms_frm;
  wire kb_take = ~rx_full_q & kb_rxv;
  wire ms_take = ~rx_full_q & ~kb_rxv & ms_rxv;

  ps2_link_engine #(
    .TMO_TX_FIRST (TMO_TX_FIRST),
    .TMO_TX_FRAME (TMO_TX_FRAME),
    .TMO_TX_ACK   (TMO_TX_ACK),
    .TMO_RX_FRAME (TMO_RX_FRAME)
  ) u_kb_link (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .enable   (1'b1),
    .inhibit  (rx_full_q),
    .line_s   ('{clk: kb_clock_in_s, data: kb_data_s}),
    .tx_valid (kb_tx_req),
    .tx_byte  (wr_data_q),
    .tx_ready (kb_rdy),
    .rx_valid (kb_rxv),
    .rx_frame (kb_frm),
    .rx_ack   (kb_take),
    .timeout  (kb_tmo),
    .busy     (kb_busy),
    .clk_oe   (keyboard_clock_line_oe),
    .data_out (keyboard_data_line_out),
    .data_oe  (keyboard_data_line_oe)
  );

  // Mouse link exists only in the second mode and obeys the lock
  ps2_link_engine #(
    .TMO_TX_FIRST (TMO_TX_FIRST),
    .TMO_TX_FRAME (TMO_TX_FRAME),
    .TMO_TX_ACK   (TMO_TX_ACK),
    .TMO_RX_FRAME (TMO_RX_FRAME)
  ) u_ms_link (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .enable   (mode_s),
    .inhibit  (rx_full_q | lock_on),
    .line_s   ('{clk: kb_data_or_mouse_clock_in_s, data: mdat_s}),
    .tx_valid (ms_tx_req & ~lock_on),
    .tx_byte  (wr_data_q),
    .tx_ready (ms_rdy),
    .rx_valid (ms_rxv),
    .rx_frame (ms_frm),
    .rx_ack   (ms_take),
    .timeout  (ms_tmo),
    .busy     (ms_busy),
    .clk_oe   (mouse_clock_line_oe),
    .data_out (mouse_data_line_out),
    .data_oe  (mouse_data_line_oe)
  );

  // Receive buffer, sticky timeout and per-byte parity flag; set wins
  logic [7:0] rx_buf_q;
  wire data_rd_end = rd_end & ~rd_a0_q;
  wire stat_rd_end = rd_end & rd_a0_q;
  wire any_tmo     = kb_tmo | ms_tmo;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_full_q  <= 1'b0;
      rx_mouse_q <= 1'b0;
      rx_buf_q   <= '0;
      tmo_q      <= 1'b0;
      par_q      <= 1'b0;
    end
    else
    begin
      rx_full_q <= kb_take | ms_take | (rx_full_q & ~data_rd_end);
      tmo_q     <= any_tmo | (tmo_q & ~stat_rd_end);
      if (kb_take | ms_take)
      begin
        rx_buf_q   <= kb_take ? kb_frm.data : ms_frm.data;
        rx_mouse_q <= ms_take;
        par_q      <= kb_take ? kb_frm.parity_err : ms_frm.parity_err;
      end
    end
  end

  // Read data; drive holds one clock past release
  logic [7:0] rd_q;
  logic [7:0] status;
  always_comb
  begin
    status                     = '0;
    status[`KBC_ST_RX_FULL]    = rx_full_q;
    status[`KBC_ST_TX_BUSY]    = ~kb_rdy | (mode_s & ~ms_rdy);
    status[`KBC_ST_LOCK]       = lock_on;
    status[`KBC_ST_LAST_CMD]   = last_cmd_q;
    status[`KBC_ST_KEYLOCK_N]  = inonly_s[`KBC_KEYLOCK_BIT];
    status[`KBC_ST_RX_MOUSE]   = rx_mouse_q;
    status[`KBC_ST_TIMEOUT]    = tmo_q;
    status[`KBC_ST_PARITY]     = par_q;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_q <= '0;
    else if (rd_act)
      rd_q <= ctl_s.cmd_data_select ? status : rx_buf_q;
  end

  assign host_data_out = rd_q;
  assign host_data_oe  = rd_act | rd_act_q;

  // Output port; the system-reset bit waits out its delay counter
  logic [7:0]          outport_q;
  logic                sysrst_pend_q, sysrst_val_q;
  logic [SYSRST_W-1:0] sysrst_cnt_q;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      outport_q     <= `KBC_OUTPORT_RST;
      sysrst_pend_q <= 1'b0;
      sysrst_val_q  <= 1'b1;
      sysrst_cnt_q  <= '0;
    end
    else if (outport_wr)
    begin
      outport_q[7:1] <= wr_data_q[7:1];
      sysrst_val_q   <= wr_data_q[`KBC_SYSRST_BIT];
      sysrst_pend_q  <= 1'b1;
      sysrst_cnt_q   <= SYSRST_CYC;
    end
    else if (sysrst_pend_q)
    begin
      sysrst_cnt_q <= sysrst_cnt_q - 1'b1;
      if (sysrst_cnt_q == '0)
      begin
        outport_q[`KBC_SYSRST_BIT] <= sysrst_val_q;
        sysrst_pend_q              <= 1'b0;
      end
    end
  end

  assign output_port_bits = outport_q;

  // Open-drain port bits, brief pull-up after a one
  logic [BIDIR_BITS-1:0] bidir_q;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      bidir_q <= `KBC_BIDIR_RST;
    else if (bidir_wr)
      bidir_q <= wr_data_q[BIDIR_BITS-1:0];
  end

  genvar gi;
  generate
    for (gi = 0; gi < BIDIR_BITS; gi++)
    begin : g_bidir
      logic [1:0] drv_q;
      always_ff @(posedge sys_clk or negedge reset_n)
      begin
        if (!reset_n)
          drv_q <= '0;
        else if (bidir_wr & wr_data_q[gi])
          drv_q <= DRIVE_CYC;
        else if (drv_q != '0)
          drv_q <= drv_q - 1'b1;
      end
      assign bidir_port_bits_out[gi] = bidir_q[gi];
      assign bidir_port_bits_oe[gi]  = ~bidir_q[gi] | (drv_q != '0);
    end
  endgenerate

  // Debug output: link activity
  logic dbg_q;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      dbg_q <= 1'b0;
    else
      dbg_q <= kb_busy | ms_busy;
  end

  assign debug_sync              = dbg_q;
  assign keyboard_clock_line_out = 1'b0;
  assign mouse_clock_line_out    = 1'b0;

endmodule

// ---- kbc_cfg.svh ----
/*
  Timing figures, command codes and reset values.
  Assumes a 10 MHz system clock.
*/
`ifndef KBC_CFG_SVH
`define KBC_CFG_SVH

// Clock rate and time conversion (integer MHz keeps products small)
`define KBC_CLK_MHZ               10
`define KBC_US_TO_CYC(us)         ((us) * `KBC_CLK_MHZ)

// Serial link times in microseconds, and frame length in bits
`define KBC_TX_REQ_US             250
`define KBC_HOLD_US               60
`define KBC_TX_FIRST_CLK_MAX_US   15000
`define KBC_TX_FRAME_MAX_US       2000
`define KBC_TX_ACK_MAX_US         2000
`define KBC_RX_FRAME_MAX_US       2000
`define KBC_FRAME_BITS            10

// Port pull-up drive: one 8 MHz cycle, rounded up to system clocks
`define KBC_PULLUP_DRIVE_NS       125
`define KBC_PULLUP_DRIVE_CYC      ((`KBC_PULLUP_DRIVE_NS * `KBC_CLK_MHZ + 999) / 1000)

// System-reset bit delay window in microseconds
`define KBC_SYSRST_DELAY_MIN_US   4
`define KBC_SYSRST_DELAY_MAX_US   8

// Host command codes that redirect the next data write
`define KBC_CMD_WR_OUTPORT        8'hd1
`define KBC_CMD_WR_BIDIR          8'hd2
`define KBC_CMD_WR_MOUSE          8'hd4

// Status byte bit positions
`define KBC_ST_RX_FULL            0
`define KBC_ST_TX_BUSY            1
`define KBC_ST_LOCK               2
`define KBC_ST_LAST_CMD           3
`define KBC_ST_KEYLOCK_N          4
`define KBC_ST_RX_MOUSE           5
`define KBC_ST_TIMEOUT            6
`define KBC_ST_PARITY             7

// Reset values and fixed positions
`define KBC_OUTPORT_RST           8'hff
`define KBC_BIDIR_RST             6'h3f
`define KBC_SYSRST_BIT            0
`define KBC_KEYLOCK_BIT           1

`endif

// ---- kbc_pkg.sv ----
/*
  Types shared by the keyboard controller top and its serial link engine.
  Assumes kbc_cfg.svh supplies every numeric constant.
*/
package kbc_pkg;

  // Host strobes as seen on the pins, all active low except the select
  typedef struct packed {
    logic wr_n;
    logic rd_n;
    logic cs_n;
    logic cmd_data_select;
  } host_ctl_s;

  // One synchronised clock/data pair of a serial link
  typedef struct packed {
    logic clk;
    logic data;
  } serial_line_s;

  // Received byte with its check result
  typedef struct packed {
    logic [7:0] data;
    logic       parity_err;
  } rx_frame_s;

  // Pending redirection of the next host data write
  typedef enum logic [1:0] {
    DST_KEYBOARD,
    DST_MOUSE,
    DST_OUTPORT,
    DST_BIDIR
  } data_dest_e;

  typedef enum logic [2:0] {
    LS_IDLE,
    LS_TX_REQ,
    LS_TX_WAIT,
    LS_TX_BITS,
    LS_TX_ACK,
    LS_HOLD,
    LS_RX_BITS
  } link_state_e;

  typedef logic [17:0] tmo_cnt_t;

endpackage

// ---- ps2_link_engine.sv ----
/*
  One two-wire serial link engine: sends and receives framed bytes.
  Assumes synchronised inputs and open-drain lines with pull-ups.
*/
`timescale 1ns/1ps
`include "kbc_cfg.svh"

module ps2_link_engine #(
  parameter int unsigned TMO_TX_FIRST = `KBC_US_TO_CYC(`KBC_TX_FIRST_CLK_MAX_US),
  parameter int unsigned TMO_TX_FRAME = `KBC_US_TO_CYC(`KBC_TX_FRAME_MAX_US),
  parameter int unsigned TMO_TX_ACK   = `KBC_US_TO_CYC(`KBC_TX_ACK_MAX_US),
  parameter int unsigned TMO_RX_FRAME = `KBC_US_TO_CYC(`KBC_RX_FRAME_MAX_US)
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // Control
  input  wire logic                 enable,
  input  wire logic                 inhibit,
  input  wire kbc_pkg::serial_line_s line_s,
  // Byte interface
  input  wire logic                 tx_valid,
  input  wire logic [7:0]           tx_byte,
  output logic                      tx_ready,
  output logic                      rx_valid,
  output kbc_pkg::rx_frame_s        rx_frame,
  input  wire logic                 rx_ack,
  output logic                      timeout,
  output logic                      busy,
  // Line drivers
  output logic                      clk_oe,
  output logic                      data_out,
  output logic                      data_oe
);
  import kbc_pkg::*;

  link_state_e state_q, state_d;
  tmo_cnt_t    cnt_q;
  tmo_cnt_t    limit;
  logic [3:0]  bit_q;
  logic [9:0]  shift_q;
  logic        clk_prev_q;
  logic        stop_rel_q;
  logic        data_out_q;
  logic        timeout_q;
  logic        rx_valid_q;
  rx_frame_s   rx_frame_q;

  // Edge detection on the synchronised clock only
  wire clk_fall = clk_prev_q & ~line_s.clk;
  wire clk_rise = ~clk_prev_q & line_s.clk;
  wire last_bit = (bit_q == 4'(`KBC_FRAME_BITS - 1));
  wire expired  = (cnt_q >= limit - tmo_cnt_t'(1));
  wire ack_bad  = (state_q == LS_TX_ACK) & clk_fall & line_s.data;
  wire tx_take  = (state_q == LS_IDLE) & enable & tx_valid;
  wire rx_done  = (state_q == LS_RX_BITS) & clk_fall & last_bit;
  wire [7:0] rx_byte = shift_q[8:1];
  wire rx_par_bad = ~(^{rx_byte, shift_q[9]}) | ~line_s.data;

  // Per-state bound: fixed low times or timeout maxima
  assign limit = (state_q == LS_TX_REQ)  ? tmo_cnt_t'(`KBC_US_TO_CYC(`KBC_TX_REQ_US)) :
                 (state_q == LS_HOLD)    ? tmo_cnt_t'(`KBC_US_TO_CYC(`KBC_HOLD_US)) :
                 (state_q == LS_TX_WAIT) ? tmo_cnt_t'(TMO_TX_FIRST) :
                 (state_q == LS_TX_BITS) ? tmo_cnt_t'(TMO_TX_FRAME) :
                 (state_q == LS_TX_ACK)  ? tmo_cnt_t'(TMO_TX_ACK) :
                                           tmo_cnt_t'(TMO_RX_FRAME);

  // Next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      LS_IDLE:
        if (tx_take)
          state_d = LS_TX_REQ;
        else if (enable & ~inhibit & ~rx_valid_q & clk_fall & ~line_s.data)
          state_d = LS_RX_BITS;
      LS_TX_REQ:  if (expired) state_d = LS_TX_WAIT;
      LS_TX_WAIT: if (clk_fall) state_d = LS_TX_BITS; else if (expired) state_d = LS_IDLE;
      LS_TX_BITS:
        if (clk_fall & last_bit)
          state_d = LS_TX_ACK;
        else if (expired)
          state_d = LS_IDLE;
      LS_TX_ACK:
        if (clk_fall)
          state_d = line_s.data ? LS_IDLE : LS_HOLD;
        else if (expired)
          state_d = LS_IDLE;
      LS_HOLD:    if (expired) state_d = LS_IDLE;
      LS_RX_BITS: if (rx_done) state_d = LS_HOLD; else if (expired) state_d = LS_IDLE;
      default:    state_d = LS_IDLE;
    endcase
    if (!enable)
      state_d = LS_IDLE;
  end

  // State and phase counter; idle keeps the counter parked
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q    <= LS_IDLE;
      cnt_q      <= '0;
      clk_prev_q <= 1'b1;
    end
    else
    begin
      state_q    <= state_d;
      cnt_q      <= (state_d != state_q || state_q == LS_IDLE) ? '0 : cnt_q + 1'b1;
      clk_prev_q <= line_s.clk;
    end
  end

  // Transmit loads stop, parity, data; receive shifts in
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_q    <= '0;
      bit_q      <= '0;
      data_out_q <= 1'b1;
    end
    else if (tx_take)
    begin
      shift_q    <= {1'b1, ~^tx_byte, tx_byte};
      bit_q      <= '0;
      data_out_q <= 1'b0; // Start bit held from the request onward
    end
    else if (clk_fall & (state_q == LS_TX_WAIT || state_q == LS_TX_BITS))
    begin
      data_out_q <= shift_q[bit_q];
      bit_q      <= bit_q + 1'b1;
    end
    else if (clk_fall & (state_q == LS_RX_BITS))
    begin
      shift_q <= {line_s.data, shift_q[9:1]};
      bit_q   <= bit_q + 1'b1;
    end
    else if (state_q == LS_IDLE)
      bit_q <= '0;
  end

  // Stop release and result flags; set wins over ack
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stop_rel_q <= 1'b0;
      timeout_q  <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_frame_q <= '0;
    end
    else
    begin
      stop_rel_q <= (state_q == LS_TX_ACK) & (stop_rel_q | clk_rise);
      timeout_q  <= ((state_d == LS_IDLE) & (state_q != LS_IDLE) & (state_q != LS_HOLD)
                     & expired) | ack_bad;
      rx_valid_q <= rx_done | (rx_valid_q & ~rx_ack);
      if (rx_done)
        rx_frame_q <= '{data: rx_byte, parity_err: rx_par_bad};
    end
  end

  // Line drivers: clock only ever pulled low
  assign clk_oe   = (state_q == LS_TX_REQ) | (state_q == LS_HOLD) |
                    ((state_q == LS_IDLE) & enable & (inhibit | rx_valid_q));
  assign data_oe  = (state_q == LS_TX_REQ) | (state_q == LS_TX_WAIT) |
                    (state_q == LS_TX_BITS) | ((state_q == LS_TX_ACK) & ~stop_rel_q);
  assign data_out = data_out_q;
  assign tx_ready = (state_q == LS_IDLE) & enable;
  assign rx_valid = rx_valid_q;
  assign rx_frame = rx_frame_q;
  assign timeout  = timeout_q;
  assign busy     = (state_q != LS_IDLE);

endmodule

// ---- kbc_pin_props.sv ----
/* Pin checks for the core.
   Bound to the top; one clock, async low reset. */
`timescale 1ns/1ps
module kbc_pin_props #(parameter int unsigned BIDIR_BITS = 6) (
  // Clock and reset
  input wire logic                  sys_clk,
  input wire logic                  reset_n,
  // Watched pins
  input wire kbc_pkg::host_ctl_s    host_ctl,
  input wire logic                  host_data_oe,
  input wire logic                  keyboard_clock_line_oe,
  input wire logic                  keyboard_data_line_out,
  input wire logic                  keyboard_data_line_oe,
  input wire logic [BIDIR_BITS-1:0] bidir_port_bits_out,
  input wire logic [BIDIR_BITS-1:0] bidir_port_bits_oe,
  input wire logic [7:0]            output_port_bits,
  input wire logic                  debug_sync
);
  import kbc_pkg::*;
  logic [11:0] lo_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Length of the current clock pull, judged where it ends
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      lo_q <= 12'h0;
    else
      lo_q <= keyboard_clock_line_oe ? lo_q + 12'h1 : 12'h0;
  sequence rd_on; !host_ctl.rd_n && !host_ctl.cs_n; endsequence
  sequence hi_on; bidir_port_bits_oe[0] && bidir_port_bits_out[0]; endsequence
  reset_state_a: assert property ($rose(reset_n) |-> output_port_bits == 8'hff)
    else $error("bad reset state");
  read_drive_a: assert property (rd_on [*5] |-> host_data_oe)
    else $error("read data not driven");
  read_hold_a: assert property (rd_on [*5] ##1 host_ctl.rd_n |->
    host_data_oe [*2] ##[1:3] !host_data_oe) else $error("read hold wrong");
  pullup_pulse_a: assert property (hi_on ##1 hi_on |=> !bidir_port_bits_oe[0])
    else $error("high drive too long");
  drive_low_a: assert property ((~bidir_port_bits_out & ~bidir_port_bits_oe) == '0)
    else $error("zero bit not driven");
  req_low_a: assert property ($fell(keyboard_clock_line_oe) && keyboard_data_line_oe
    |-> lo_q == 12'h9c4) else $error("request pull length");
  start_bit_a: assert property ($rose(keyboard_data_line_oe) |-> !keyboard_data_line_out)
    else $error("start bit not low");
  busy_flag_a: assert property ($rose(keyboard_data_line_oe) |-> ##[0:2] debug_sync)
    else $error("debug output idle");
endmodule
bind kbc_host_port_and_serial_link kbc_pin_props #(.BIDIR_BITS(BIDIR_BITS)) props (
  .sys_clk(sys_clk), .reset_n(reset_n), .host_ctl(host_ctl), .host_data_oe(host_data_oe),
  .keyboard_clock_line_oe(keyboard_clock_line_oe), .debug_sync(debug_sync),
  .keyboard_data_line_out(keyboard_data_line_out), .output_port_bits(output_port_bits),
  .keyboard_data_line_oe(keyboard_data_line_oe), .bidir_port_bits_oe(bidir_port_bits_oe),
  .bidir_port_bits_out(bidir_port_bits_out));

// ---- kb_device_model.sv ----
/* Keyboard model on the two-wire link, 800 ns clock.
   The bench resolves the lines; this only pulls low. */
`timescale 1ns/1ps
module kb_device_model (
  // Resolved lines
  input wire logic clk_line,
  input wire logic data_line,
  // Pulls toward low
  output logic     clk_low = 1'b0,
  output logic     data_low = 1'b0
);
  logic [9:0] frame;
  logic       mute = 1'b0;
  int         n_rx = 0;
  // One clock period; clock idles between frames
  task automatic tick;
    #400 clk_low = 1'b1;
    #400 clk_low = 1'b0;
  endtask
  // Answers a request
  always
  begin
    wait (clk_line && !data_line && !data_low && !mute);
    frame[0] = data_line;
    for (int i = 1; i < 10; i++)
    begin
      tick();
      frame[i] = data_line;
    end
    tick();
    data_low = 1'b1;
    tick();
    data_low = 1'b0;
    n_rx++;
  end
  // Sends a byte once the clock is free
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ~^b, b, 1'b0};
    wait (clk_line);
    for (int i = 0; i < 11; i++)
    begin
      data_low = !f[i];
      tick();
    end
    data_low = 1'b0;
  endtask
endmodule

// ---- test_kbc_host_port_and_serial_link.sv ----
/* Bench: host port, keyboard link, port bits, output port.
   Assumes kb_device_model; mode 0. */
`timescale 1ns/1ps
module test_kbc_host_port_and_serial_link;
  import kbc_pkg::*;
  logic      sys_clk = 1'b0;
  logic      reset_n = 1'b0;
  host_ctl_s host_ctl = 4'he;
  logic [7:0] host_data_in = 8'h00;
  logic [7:0] host_data_out, output_port_bits, s;
  logic      host_data_oe, kc_oe, kd_out, kd_oe, clk_low, data_low, kb_clk, kb_dat;
  logic [5:0] bp_out, bp_oe, bp_in;
  logic      mode = 1'b0, strap_n = 1'b1, ms_dat = 1'b1;
  logic [1:0] in_only = 2'h3;
  int        err_total = 0;
  int        n_compared = 0;
  int        cyc = 0;
  always #50 sys_clk = ~sys_clk;
  // Open-drain wires with pull-ups
  assign kb_clk = !(kc_oe || clk_low);
  assign kb_dat = !((kd_oe && !kd_out) || data_low);
  assign bp_in = ~(bp_oe & ~bp_out);
  kbc_host_port_and_serial_link #(.TMO_TX_FIRST(3000), .TMO_TX_FRAME(2000),
    .TMO_TX_ACK(2000), .TMO_RX_FRAME(2000)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .host_ctl(host_ctl), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .ps2_mode(mode), .lock_enable_strap_n(strap_n),
    .kb_clock_in(kb_clk), .kb_data_or_mouse_clock_in(kb_dat),
    .keyboard_clock_line_out(), .keyboard_clock_line_oe(kc_oe), .keyboard_data_line_in(kb_dat),
    .keyboard_data_line_out(kd_out), .keyboard_data_line_oe(kd_oe), .mouse_clock_line_out(),
    .mouse_clock_line_oe(), .mouse_data_line_in(ms_dat), .mouse_data_line_out(),
    .mouse_data_line_oe(), .bidir_port_bits_in(bp_in), .bidir_port_bits_out(bp_out),
    .bidir_port_bits_oe(bp_oe), .input_only_bits(in_only), .output_port_bits(output_port_bits),
    .debug_sync());
  kb_device_model ps (.clk_line(kb_clk), .data_line(kb_dat), .clk_low(clk_low),
    .data_low(data_low));
  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One host access, strobe low six clocks
  task automatic host(input logic rd, input logic sel, input logic [7:0] d);
    repeat (4) @(posedge sys_clk);
    host_ctl <= {rd, !rd, 1'b0, sel};
    host_data_in <= d;
    repeat (5) @(posedge sys_clk);
    #1 s = host_data_out;
    @(posedge sys_clk);
    host_ctl <= {3'h7, sel};
  endtask
  task automatic t_ports;
    cmp(output_port_bits, 8'hff);
    host(0, 1, 8'hd1);
    host(0, 0, 8'h5a);
    repeat (6) @(posedge sys_clk);
    #1 cmp(output_port_bits, 8'h5b);
    repeat (32) @(posedge sys_clk);
    #1 cmp(output_port_bits, 8'h5b);
    repeat (42) @(posedge sys_clk);
    #1 cmp(output_port_bits, 8'h5a);
    host(0, 1, 8'hd2);
    host(0, 0, 8'h3e);
    repeat (8) @(posedge sys_clk);
    #1 cmp(bp_oe, 6'h01);
    cmp(bp_in, 6'h3e);
    host(0, 1, 8'hd2);
    host(0, 0, 8'h3f);
    repeat (8) @(posedge sys_clk);
    #1 cmp(bp_oe, 6'h00);
    cmp(bp_in, 6'h3f);
    $display("ports done");
  endtask
  task automatic t_tx;
    int n;
    n = ps.n_rx;
    host(0, 0, 8'ha5);
    for (int i = 0; i < 5000 && ps.n_rx == n; i++)
      @(posedge sys_clk);
    cmp(ps.frame, {1'b1, 8'ha5, 1'b0});
    repeat (700) @(posedge sys_clk);
    host(1, 1, 8'h00);
    cmp(s[6], 1'b0);
    $display("transmit done");
  endtask
  task automatic t_rx;
    ps.send(8'h3c);
    repeat (700) @(posedge sys_clk);
    host(1, 1, 8'h00);
    cmp(s[0], 1'b1);
    host(1, 0, 8'h00);
    cmp(s, 8'h3c);
    $display("receive done");
  endtask
  // Silent keyboard: timeout, cleared by read
  task automatic t_tmo;
    ps.mute = 1'b1;
    host(0, 0, 8'h11);
    repeat (6000) @(posedge sys_clk);
    host(1, 1, 8'h00);
    cmp(s[6], 1'b1);
    host(1, 1, 8'h00);
    cmp(s[6], 1'b0);
    ps.mute = 1'b0;
    $display("timeout done");
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_ports();
    t_tx();
    t_rx();
    t_tmo();
    close_out();
  end
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total++;
      close_out();
    end
  end
endmodule
